// ===== src/radmc_regs.sv
// Radio and modem configuration register bank with readback of receive measurements
`timescale 1ns/10ps
`default_nettype none

module radmc_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [radmc_pkg::ADDR_W-1:0] host_addr,
    input wire logic host_wr_en,
    input wire logic [7:0] host_wr_data,
    input wire logic host_rd_en,
    output logic [7:0] host_rd_data,
    output logic host_rd_valid,
    input wire logic [7:0] rssi_in,
    input wire logic [7:0] sqi_in,
    input wire logic ctrl_upd_en,
    input wire logic [radmc_pkg::CTRL_W-1:0] ctrl_upd_bits,
    output radmc_pkg::radmc_mode_t packet_format_select,
    output logic [radmc_pkg::CHW_W-1:0] channel_frequency_word,
    output logic [radmc_pkg::DEVK_W-1:0] tx_dev_khz,
    output logic [radmc_pkg::DBW_W-1:0] demod_bandwidth_factor,
    output logic gauss_en,
    output logic preemph_en,
    output logic [radmc_pkg::CTRL_W-1:0] controller_owned_bits,
    output logic [radmc_pkg::RATE_W-1:0] data_rate_bps,
    output logic [radmc_pkg::PAGE_W-1:0] pram_page,
    output logic [7:0] tx_pkt_base,
    output logic [7:0] rx_pkt_base
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] mode_byte, next_mode_byte;     // Packet format byte
    logic [7:0] ch_low, next_ch_low;           // Channel word low byte
    logic [7:0] ch_mid, next_ch_mid;           // Channel word mid byte
    logic [7:0] ch_high, next_ch_high;         // Channel word high byte
    logic [7:0] dev_byte, next_dev_byte;       // Deviation byte
    logic [7:0] dbw_byte, next_dbw_byte;       // Discriminator byte
    logic [7:0] mod_byte, next_mod_byte;       // Modulation control byte
    logic [7:0] rate_hi, next_rate_hi;         // Data rate high byte
    logic [7:0] rate_lo, next_rate_lo;         // Data rate low byte
    logic [7:0] page_byte, next_page_byte;     // Program RAM page byte
    logic [7:0] txb_byte, next_txb_byte;       // Transmit buffer base
    logic [7:0] rxb_byte, next_rxb_byte;       // Receive buffer base
    logic [7:0] rssi_q, next_rssi_q;           // Captured received power
    logic [7:0] sqi_q, next_sqi_q;             // Captured signal quality

    radmc_cfg_if cfg ();

    // ------------------------------------------------------------
    // Derivation of engineering values
    // ------------------------------------------------------------
    radmc_derive u_derive (
        .cfg (cfg.calc)
    );

    assign cfg.mode_byte = mode_byte;
    assign cfg.ch_low = ch_low;
    assign cfg.ch_mid = ch_mid;
    assign cfg.ch_high = ch_high;
    assign cfg.dev_byte = dev_byte;
    assign cfg.rate_hi = rate_hi;
    assign cfg.rate_lo = rate_lo;

    // ------------------------------------------------------------
    // Register write path
    // ------------------------------------------------------------
    // Host writes land on the next edge; read-only offsets and unknown offsets ignore writes
    always_comb begin
        next_mode_byte = mode_byte;
        next_ch_low = ch_low;
        next_ch_mid = ch_mid;
        next_ch_high = ch_high;
        next_dev_byte = dev_byte;
        next_dbw_byte = dbw_byte;
        next_mod_byte = mod_byte;
        next_rate_hi = rate_hi;
        next_rate_lo = rate_lo;
        next_page_byte = page_byte;
        next_txb_byte = txb_byte;
        next_rxb_byte = rxb_byte;
        // Measurements are sampled every cycle so readback is never stale by more than two
        next_rssi_q = rssi_in;
        next_sqi_q = sqi_in;
        if (host_wr_en) begin
            case (host_addr)
                radmc_pkg::OFF_PKT_FMT: begin
                    next_mode_byte = host_wr_data;
                end
                radmc_pkg::OFF_CH_LOW: begin
                    next_ch_low = host_wr_data;
                end
                radmc_pkg::OFF_CH_MID: begin
                    next_ch_mid = host_wr_data;
                end
                radmc_pkg::OFF_CH_HIGH: begin
                    next_ch_high = host_wr_data;
                end
                radmc_pkg::OFF_TX_DEV: begin
                    next_dev_byte = host_wr_data;
                end
                radmc_pkg::OFF_DEMOD_BW: begin
                    next_dbw_byte = host_wr_data;
                end
                radmc_pkg::OFF_TX_MOD: begin
                    // Only the two filter bits are software's; the rest stay with the controller
                    next_mod_byte = {mod_byte[7:radmc_pkg::CTRL_LSB],
                                     host_wr_data[radmc_pkg::CTRL_LSB-1:0]};
                end
                radmc_pkg::OFF_RATE_HI: begin
                    next_rate_hi = host_wr_data;
                end
                radmc_pkg::OFF_RATE_LO: begin
                    next_rate_lo = host_wr_data;
                end
                radmc_pkg::OFF_PRAM_PG: begin
                    next_page_byte = host_wr_data;
                end
                radmc_pkg::OFF_TX_BASE: begin
                    next_txb_byte = host_wr_data;
                end
                radmc_pkg::OFF_RX_BASE: begin
                    next_rxb_byte = host_wr_data;
                end
                default: begin
                    // Read-only and unmapped offsets keep their state
                end
            endcase
        end
        // Radio controller updates its own field at any time
        if (ctrl_upd_en) begin
            next_mod_byte[7:radmc_pkg::CTRL_LSB] = ctrl_upd_bits;
        end
    end

    // Register update and reset values
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_byte <= radmc_pkg::RST_PKT_FMT;
            ch_low <= radmc_pkg::RST_CH_LOW;
            ch_mid <= radmc_pkg::RST_CH_MID;
            ch_high <= radmc_pkg::RST_CH_HIGH;
            dev_byte <= radmc_pkg::RST_TX_DEV;
            dbw_byte <= radmc_pkg::RST_DEMOD_BW;
            mod_byte <= radmc_pkg::RST_TX_MOD;
            rate_hi <= radmc_pkg::RST_RATE_HI;
            rate_lo <= radmc_pkg::RST_RATE_LO;
            page_byte <= radmc_pkg::RST_PRAM_PG;
            txb_byte <= radmc_pkg::RST_TX_BASE;
            rxb_byte <= radmc_pkg::RST_RX_BASE;
            rssi_q <= radmc_pkg::RST_READBACK;
            sqi_q <= radmc_pkg::RST_READBACK;
        end else begin
            mode_byte <= next_mode_byte;
            ch_low <= next_ch_low;
            ch_mid <= next_ch_mid;
            ch_high <= next_ch_high;
            dev_byte <= next_dev_byte;
            dbw_byte <= next_dbw_byte;
            mod_byte <= next_mod_byte;
            rate_hi <= next_rate_hi;
            rate_lo <= next_rate_lo;
            page_byte <= next_page_byte;
            txb_byte <= next_txb_byte;
            rxb_byte <= next_rxb_byte;
            rssi_q <= next_rssi_q;
            sqi_q <= next_sqi_q;
        end
    end

    // ------------------------------------------------------------
    // Read path and block outputs
    // ------------------------------------------------------------
    logic [7:0] next_rd_data;   // Read data for the next cycle
    logic next_rd_valid;        // Read strobe delayed by one

    // Reads return the stored byte whole, reserved bits included, so a read-modify-write keeps them
    always_comb begin
        next_rd_valid = host_rd_en;
        next_rd_data = host_rd_data;
        if (host_rd_en) begin
            case (host_addr)
                radmc_pkg::OFF_PKT_FMT: next_rd_data = mode_byte;
                radmc_pkg::OFF_CH_LOW: next_rd_data = ch_low;
                radmc_pkg::OFF_CH_MID: next_rd_data = ch_mid;
                radmc_pkg::OFF_CH_HIGH: next_rd_data = ch_high;
                radmc_pkg::OFF_TX_DEV: next_rd_data = dev_byte;
                radmc_pkg::OFF_DEMOD_BW: next_rd_data = dbw_byte;
                radmc_pkg::OFF_TX_MOD: next_rd_data = mod_byte;
                radmc_pkg::OFF_RX_POWER: next_rd_data = rssi_q;
                radmc_pkg::OFF_SIG_QUAL: next_rd_data = sqi_q;
                radmc_pkg::OFF_RATE_HI: next_rd_data = rate_hi;
                radmc_pkg::OFF_RATE_LO: next_rd_data = rate_lo;
                radmc_pkg::OFF_PRAM_PG: next_rd_data = page_byte;
                radmc_pkg::OFF_TX_BASE: next_rd_data = txb_byte;
                radmc_pkg::OFF_RX_BASE: next_rd_data = rxb_byte;
                default: next_rd_data = radmc_pkg::UNMAPPED_DATA;
            endcase
        end
    end

    // Outputs are flopped; derived values lag a write by two edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            host_rd_data <= radmc_pkg::RST_READBACK;
            host_rd_valid <= 1'b0;
            packet_format_select <= radmc_pkg::RADMC_STD_PKT;
            channel_frequency_word <= {radmc_pkg::RST_CH_HIGH, radmc_pkg::RST_CH_MID, radmc_pkg::RST_CH_LOW};
            tx_dev_khz <= radmc_pkg::DEVK_W'(radmc_pkg::RST_TX_DEV[radmc_pkg::DEV_W-1:0])
                          * radmc_pkg::DEV_STEP_KHZ;
            demod_bandwidth_factor <= radmc_pkg::RST_DEMOD_BW[radmc_pkg::DBW_W-1:0];
            gauss_en <= radmc_pkg::RST_TX_MOD[radmc_pkg::GAUSS_BIT];
            preemph_en <= radmc_pkg::RST_TX_MOD[radmc_pkg::PREEMP_BIT];
            controller_owned_bits <= radmc_pkg::RST_TX_MOD[7:radmc_pkg::CTRL_LSB];
            data_rate_bps <= radmc_pkg::RATE_W'({radmc_pkg::RST_RATE_HI, radmc_pkg::RST_RATE_LO})
                             * radmc_pkg::RATE_STEP_BPS;
            pram_page <= radmc_pkg::RST_PRAM_PG[radmc_pkg::PAGE_W-1:0];
            tx_pkt_base <= radmc_pkg::RST_TX_BASE;
            rx_pkt_base <= radmc_pkg::RST_RX_BASE;
        end else begin
            host_rd_data <= next_rd_data;
            host_rd_valid <= next_rd_valid;
            packet_format_select <= cfg.mode;
            channel_frequency_word <= cfg.chan_word;
            tx_dev_khz <= cfg.dev_khz;
            // Top bit is reserved and never reaches the demodulator
            demod_bandwidth_factor <= dbw_byte[radmc_pkg::DBW_W-1:0];
            gauss_en <= mod_byte[radmc_pkg::GAUSS_BIT];
            preemph_en <= mod_byte[radmc_pkg::PREEMP_BIT];
            controller_owned_bits <= mod_byte[7:radmc_pkg::CTRL_LSB];
            data_rate_bps <= cfg.rate_bps;
            pram_page <= page_byte[radmc_pkg::PAGE_W-1:0];
            tx_pkt_base <= txb_byte;
            rx_pkt_base <= rxb_byte;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mode_fsk_pkt;
        @(posedge ref_clk) disable iff (rst)
        (host_wr_en && host_addr == radmc_pkg::OFF_PKT_FMT && host_wr_data == radmc_pkg::FMT_FSK_PKT)
        ##1 !(host_wr_en && host_addr == radmc_pkg::OFF_PKT_FMT)
        |=> packet_format_select == radmc_pkg::RADMC_FSK_PKT;
    endproperty
    a_mode_fsk_pkt: assert property (p_mode_fsk_pkt) else $error("fsk packet mode not selected");

    property p_chan_low;
        @(posedge ref_clk) disable iff (rst)
        (host_wr_en && host_addr == radmc_pkg::OFF_CH_LOW)
        |-> ##2 channel_frequency_word[7:0] == $past(host_wr_data, 2);
    endproperty
    a_chan_low: assert property (p_chan_low) else $error("channel low byte not applied");

    property p_dev_scale;
        @(posedge ref_clk) disable iff (rst)
        (host_wr_en && host_addr == radmc_pkg::OFF_TX_DEV) ##1 !(host_wr_en && host_addr == radmc_pkg::OFF_TX_DEV)
        |=> tx_dev_khz == radmc_pkg::DEVK_W'($past(host_wr_data[radmc_pkg::DEV_W-1:0], 2))
                          * radmc_pkg::DEV_STEP_KHZ;
    endproperty
    a_dev_scale: assert property (p_dev_scale) else $error("deviation not ten times field");

    property p_dbw_mask;
        @(posedge ref_clk) disable iff (rst)
        (host_wr_en && host_addr == radmc_pkg::OFF_DEMOD_BW)
        |-> ##2 demod_bandwidth_factor == $past(host_wr_data[radmc_pkg::DBW_W-1:0], 2);
    endproperty
    a_dbw_mask: assert property (p_dbw_mask) else $error("discriminator factor wrong");

    property p_filter_bits;
        @(posedge ref_clk) disable iff (rst)
        (host_wr_en && host_addr == radmc_pkg::OFF_TX_MOD)
        |-> ##2 {gauss_en, preemph_en} == $past(host_wr_data[radmc_pkg::CTRL_LSB-1:0], 2);
    endproperty
    a_filter_bits: assert property (p_filter_bits) else $error("filter enables wrong");

    property p_ctrl_owned;
        @(posedge ref_clk) disable iff (rst)
        !ctrl_upd_en |=> mod_byte[7:radmc_pkg::CTRL_LSB] == $past(mod_byte[7:radmc_pkg::CTRL_LSB]);
    endproperty
    a_ctrl_owned: assert property (p_ctrl_owned) else $error("host changed controller bits");

    property p_rssi_rb;
        @(posedge ref_clk) disable iff (rst)
        (host_rd_en && host_addr == radmc_pkg::OFF_RX_POWER) |=> host_rd_valid && host_rd_data == $past(rssi_in, 2);
    endproperty
    a_rssi_rb: assert property (p_rssi_rb) else $error("power readback wrong");

    property p_sqi_rb;
        @(posedge ref_clk) disable iff (rst)
        (host_rd_en && host_addr == radmc_pkg::OFF_SIG_QUAL) |=> host_rd_data == $past(sqi_in, 2);
    endproperty
    a_sqi_rb: assert property (p_sqi_rb) else $error("quality readback wrong");

    property p_rate_low;
        @(posedge ref_clk) disable iff (rst)
        (host_wr_en && host_addr == radmc_pkg::OFF_RATE_LO && rate_hi == 8'h00) ##1 !host_wr_en
        |=> data_rate_bps == radmc_pkg::RATE_W'($past(host_wr_data, 2)) * radmc_pkg::RATE_STEP_BPS;
    endproperty
    a_rate_low: assert property (p_rate_low) else $error("data rate not hundred times word");

    property p_tx_base_rst;
        @(posedge ref_clk)
        rst |=> tx_pkt_base == radmc_pkg::RST_TX_BASE && rx_pkt_base == radmc_pkg::RST_RX_BASE;
    endproperty
    a_tx_base_rst: assert property (p_tx_base_rst) else $error("buffer base reset wrong");

endmodule // radmc_regs

`default_nettype wire

// ===== common/radmc_pkg.sv
// Package of register offsets, reset values, field layout and mode types for the radio config bank
`default_nettype none

package radmc_pkg;

    // ------------------------------------------------------------
    // Register addresses on the host port
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] OFF_PKT_FMT = 10'h13E;
    localparam logic [ADDR_W-1:0] OFF_CH_LOW = 10'h300;
    localparam logic [ADDR_W-1:0] OFF_CH_MID = 10'h301;
    localparam logic [ADDR_W-1:0] OFF_CH_HIGH = 10'h302;
    localparam logic [ADDR_W-1:0] OFF_TX_DEV = 10'h304;
    localparam logic [ADDR_W-1:0] OFF_DEMOD_BW = 10'h305;
    localparam logic [ADDR_W-1:0] OFF_TX_MOD = 10'h306;
    localparam logic [ADDR_W-1:0] OFF_RX_POWER = 10'h30C;
    localparam logic [ADDR_W-1:0] OFF_SIG_QUAL = 10'h30D;
    localparam logic [ADDR_W-1:0] OFF_RATE_HI = 10'h30E;
    localparam logic [ADDR_W-1:0] OFF_RATE_LO = 10'h30F;
    localparam logic [ADDR_W-1:0] OFF_PRAM_PG = 10'h313;
    localparam logic [ADDR_W-1:0] OFF_TX_BASE = 10'h314;
    localparam logic [ADDR_W-1:0] OFF_RX_BASE = 10'h315;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PKT_FMT = 8'h00;
    localparam logic [7:0] RST_CH_LOW = 8'h80;
    localparam logic [7:0] RST_CH_MID = 8'hA9;
    localparam logic [7:0] RST_CH_HIGH = 8'h03;
    localparam logic [7:0] RST_TX_DEV = 8'h32;
    localparam logic [7:0] RST_DEMOD_BW = 8'h06;
    localparam logic [7:0] RST_TX_MOD = 8'h01;
    localparam logic [7:0] RST_READBACK = 8'h00;
    localparam logic [7:0] RST_RATE_HI = 8'h4E;
    localparam logic [7:0] RST_RATE_LO = 8'h20;
    localparam logic [7:0] RST_PRAM_PG = 8'h00;
    localparam logic [7:0] RST_TX_BASE = 8'h80;
    localparam logic [7:0] RST_RX_BASE = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int DEV_W = 6;        // Deviation field [5:0]
    localparam int DBW_W = 7;        // Discriminator factor [6:0]
    localparam int PAGE_W = 4;       // Program RAM page [3:0]
    localparam int CTRL_W = 6;       // Controller-owned bits [7:2]
    localparam int CTRL_LSB = 2;
    localparam int GAUSS_BIT = 1;
    localparam int PREEMP_BIT = 0;
    localparam int CHW_W = 24;
    localparam int DEVK_W = 10;      // 63 * 10 kHz fits in 10 bits
    localparam int RATE_W = 23;      // 65535 * 100 bps fits in 23 bits

    // ------------------------------------------------------------
    // Scale factors
    // ------------------------------------------------------------
    localparam logic [DEVK_W-1:0] DEV_STEP_KHZ = 10'h00A;   // 10 kHz per step
    localparam logic [15:0] RATE_HI_WEIGHT = 16'h0100;       // High byte weight 256
    localparam logic [RATE_W-1:0] RATE_STEP_BPS = 23'h000064; // 100 bps per step

    // ------------------------------------------------------------
    // Packet format codes and decoded mode
    // ------------------------------------------------------------
    localparam logic [7:0] FMT_STD_PKT = 8'h00;
    localparam logic [7:0] FMT_STD_RX_SPORT = 8'h02;
    localparam logic [7:0] FMT_FSK_SPORT = 8'h03;
    localparam logic [7:0] FMT_FSK_PKT = 8'h04;

    typedef enum logic [2:0] {
        RADMC_STD_PKT,
        RADMC_STD_RX_SPORT,
        RADMC_FSK_SPORT,
        RADMC_FSK_PKT,
        RADMC_FMT_RESERVED
    } radmc_mode_t;

    // Reserved codes map to their own state so the controller can refuse them
    function automatic radmc_mode_t decode_mode(input logic [7:0] code);
        case (code)
            FMT_STD_PKT: decode_mode = RADMC_STD_PKT;
            FMT_STD_RX_SPORT: decode_mode = RADMC_STD_RX_SPORT;
            FMT_FSK_SPORT: decode_mode = RADMC_FSK_SPORT;
            FMT_FSK_PKT: decode_mode = RADMC_FSK_PKT;
            default: decode_mode = RADMC_FMT_RESERVED;
        endcase
    endfunction

endpackage

`default_nettype wire

// ===== common/radmc_cfg_if.sv
// Interface carrying raw register values to the derivation logic and results back
`timescale 1ns/10ps
`default_nettype none

interface radmc_cfg_if;
    logic [7:0] mode_byte;      // Packet format byte
    logic [7:0] ch_low;         // Channel word bytes
    logic [7:0] ch_mid;
    logic [7:0] ch_high;
    logic [7:0] dev_byte;       // Deviation register
    logic [7:0] rate_hi;        // Data rate bytes
    logic [7:0] rate_lo;
    logic [radmc_pkg::CHW_W-1:0] chan_word;     // Assembled channel word
    logic [radmc_pkg::DEVK_W-1:0] dev_khz;      // Deviation in kHz
    logic [radmc_pkg::RATE_W-1:0] rate_bps;     // Data rate in bps
    radmc_pkg::radmc_mode_t mode;                // Decoded packet format

    modport regs (output mode_byte, ch_low, ch_mid, ch_high, dev_byte, rate_hi, rate_lo,
                  input chan_word, dev_khz, rate_bps, mode);
    modport calc (input mode_byte, ch_low, ch_mid, ch_high, dev_byte, rate_hi, rate_lo,
                  output chan_word, dev_khz, rate_bps, mode);
endinterface

`default_nettype wire

// ===== src/radmc_derive.sv
// Combinational derivation of channel word, deviation, data rate and mode
`timescale 1ns/10ps
`default_nettype none

module radmc_derive (
    radmc_cfg_if.calc cfg
);

    // ------------------------------------------------------------
    // Derived quantities
    // ------------------------------------------------------------
    logic [15:0] rate_word; // High byte weighted by 256 plus low byte

    // Pure arithmetic; the caller registers the results before they leave the block
    always_comb begin
        cfg.chan_word = {cfg.ch_high, cfg.ch_mid, cfg.ch_low};
        // Reserved top bits of the deviation byte take no part
        cfg.dev_khz = radmc_pkg::DEVK_W'(cfg.dev_byte[radmc_pkg::DEV_W-1:0])
                      * radmc_pkg::DEV_STEP_KHZ;
        rate_word = 16'(cfg.rate_hi) * radmc_pkg::RATE_HI_WEIGHT + 16'(cfg.rate_lo);
        cfg.rate_bps = radmc_pkg::RATE_W'(rate_word) * radmc_pkg::RATE_STEP_BPS;
        cfg.mode = radmc_pkg::decode_mode(cfg.mode_byte);
    end

endmodule // radmc_derive

`default_nettype wire

// ===== test/tb_radio_modem_config_regs.sv
// Self-checking bench for the radio and modem configuration register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module tb_radio_modem_config_regs;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0, rst = 1'b1, host_wr_en = 1'b0, host_rd_en = 1'b0, ctrl_upd_en = 1'b0;
    logic [9:0] host_addr = 10'h000;
    logic [7:0] host_wr_data = 8'h00, rssi_in = 8'h00, sqi_in = 8'h00, host_rd_data, txb, rxb, b [6];
    logic [5:0] ctrl_upd_bits = 6'h00, cb;
    logic host_rd_valid, gauss_en, preemph_en;
    radmc_pkg::radmc_mode_t packet_format_select;
    logic [23:0] channel_frequency_word;
    logic [9:0] tx_dev_khz;
    logic [6:0] demod_bandwidth_factor;
    logic [5:0] controller_owned_bits;
    logic [22:0] data_rate_bps;
    logic [3:0] pram_page;
    int errors = 0, n_checks = 0, cyc = 0;
    // Offsets in rows of the register table, with their reset values
    logic [9:0] offs [14] = '{10'h13E, 10'h300, 10'h301, 10'h302, 10'h304, 10'h305, 10'h306, 10'h30C, 10'h30D,
        10'h30E, 10'h30F, 10'h313, 10'h314, 10'h315};
    logic [7:0] rstv [14] = '{8'h00, 8'h80, 8'hA9, 8'h03, 8'h32, 8'h06, 8'h01, 8'h00, 8'h00, 8'h4E, 8'h20,
        8'h00, 8'h80, 8'h00};
    // Recommended deviation and discriminator pairs, one per data rate class
    logic [7:0] rec_dev [5] = '{8'h32, 8'h19, 8'h0D, 8'h06, 8'h06};
    logic [7:0] rec_dbw [5] = '{8'h06, 8'h0D, 8'h19, 8'h37, 8'h6B};

    radmc_regs DUT (.ref_clk(ref_clk), .rst(rst), .host_addr(host_addr), .host_wr_en(host_wr_en),
        .host_wr_data(host_wr_data), .host_rd_en(host_rd_en), .host_rd_data(host_rd_data),
        .host_rd_valid(host_rd_valid), .rssi_in(rssi_in), .sqi_in(sqi_in), .ctrl_upd_en(ctrl_upd_en),
        .ctrl_upd_bits(ctrl_upd_bits), .packet_format_select(packet_format_select),
        .channel_frequency_word(channel_frequency_word), .tx_dev_khz(tx_dev_khz),
        .demod_bandwidth_factor(demod_bandwidth_factor), .gauss_en(gauss_en), .preemph_en(preemph_en),
        .controller_owned_bits(controller_owned_bits), .data_rate_bps(data_rate_bps), .pram_page(pram_page),
        .tx_pkt_base(txb), .rx_pkt_base(rxb));

    // ------------------------------------------------------------
    // Clock, bus tasks, expectation function
    // ------------------------------------------------------------
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // Reserved codes must not alias a real mode
    function automatic radmc_pkg::radmc_mode_t exp_mode(input logic [7:0] c);
        return c == 0 ? radmc_pkg::RADMC_STD_PKT : c == 2 ? radmc_pkg::RADMC_STD_RX_SPORT :
            c == 3 ? radmc_pkg::RADMC_FSK_SPORT : c == 4 ? radmc_pkg::RADMC_FSK_PKT : radmc_pkg::RADMC_FMT_RESERVED;
    endfunction

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        host_addr <= a;
        host_wr_data <= d;
        host_wr_en <= 1'b1;
        @(posedge ref_clk);
        host_wr_en <= 1'b0;
    endtask

    // Read data is looked at in the single cycle that valid stands
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        host_addr <= a;
        host_rd_en <= 1'b1;
        @(posedge ref_clk);
        host_rd_en <= 1'b0;
        // Valid rose at the edge that took the strobe and falls at the next one
        #1;
        `CHK("rd_valid", 1'b1, host_rd_valid)
        `CHK("rd_data", e, host_rd_data)
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Hang guard well above the length of the sequence below
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(57005));
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        settle();
        `CHK("chan_rst", 24'h03A980, channel_frequency_word)
        `CHK("dev_rst", 10'h1F4, tx_dev_khz)
        `CHK("rate_rst", 23'h1E8480, data_rate_bps)
        `CHK("bases_rst", 16'h8000, {txb, rxb})
        `CHK("filt_rst", 2'b01, {gauss_en, preemph_en})
        foreach (offs[i]) rd(offs[i], rstv[i]);
        rd(10'h3FF, 8'h00); // Unmapped place reads zero
        // Every defined mode code, plus the reserved codes 1, 5 and FF
        for (int c = 0; c < 7; c++) begin
            wr(10'h13E, c == 6 ? 8'hFF : c[7:0]);
            settle();
            `CHK("mode", exp_mode(c == 6 ? 8'hFF : c[7:0]), packet_format_select)
        end
        // Software programs the recommended pairs for each data rate class
        foreach (rec_dev[i]) begin
            wr(10'h304, rec_dev[i]);
            wr(10'h305, rec_dbw[i]);
            settle();
            `CHK("rec_dev", 10'(rec_dev[i][5:0]) * 10, tx_dev_khz)
            `CHK("rec_dbw", rec_dbw[i][6:0], demod_bandwidth_factor)
        end
        // Low rate byte alone while the high byte is zero
        wr(10'h30E, 8'h00);
        wr(10'h30F, 8'hC8);
        settle();
        `CHK("rate_lo_only", 23'h004E20, data_rate_bps)
        // Random configuration, all bytes written before one combined check; reserved bits kept at default
        repeat (20) begin
            foreach (b[i]) b[i] = 8'($urandom);
            b[3] = b[3] & 8'h3F;
            b[4] = b[4] & 8'h7F;
            foreach (b[i]) wr(offs[i + 1 + 3 * (i > 4)], b[i]);
            wr(10'h30F, b[5] ^ 8'h5A);
            wr(10'h305, b[4]);
            settle();
            `CHK("chan", {b[2], b[1], b[0]}, channel_frequency_word)
            `CHK("dev", 10'(b[3][5:0]) * 10, tx_dev_khz)
            `CHK("dbw", b[4][6:0], demod_bandwidth_factor)
            `CHK("rate", 23'({b[5], b[5] ^ 8'h5A}) * 100, data_rate_bps)
            rd(10'h304, b[3]);
        end
        // Readbacks follow their inputs and ignore writes
        rssi_in <= 8'hB5;
        sqi_in <= 8'($urandom);
        wr(10'h30C, 8'h11);
        wr(10'h30D, 8'h22);
        rd(10'h30C, 8'hB5);
        rd(10'h30D, sqi_in);
        // Controller update in the same cycle as a host write to the modulation byte
        cb = 6'($urandom);
        @(posedge ref_clk);
        ctrl_upd_en <= 1'b1;
        ctrl_upd_bits <= cb;
        host_addr <= 10'h306;
        host_wr_data <= 8'h02;
        host_wr_en <= 1'b1;
        @(posedge ref_clk);
        ctrl_upd_en <= 1'b0;
        host_wr_en <= 1'b0;
        settle();
        `CHK("ctrl", {cb, 2'b10}, {controller_owned_bits, gauss_en, preemph_en})
        wr(10'h306, ~cb << 2);
        rd(10'h306, {cb, 2'b00});
        wr(10'h313, 8'h07);
        wr(10'h314, 8'h3C);
        wr(10'h315, 8'hC3);
        settle();
        `CHK("page_bases", 20'h73CC3, {pram_page, txb, rxb})
        print_verdict();
    end
endmodule // tb_radio_modem_config_regs

`default_nettype wire
